// ### rtl/qpc_counter.sv
// Purpose: quadrature position counter with timer mode and wishbone registers
// Assumes: phase and index pins are asynchronous, sleep_i is on clk_i
// Notes:   software writes to the position count win over counting
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module qpc_counter
  import qpc_pkg::*;
#(
  parameter int unsigned CNT_W = 16
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        phase_a_input_i,
  input  wire logic        phase_b_input_i,
  input  wire logic        index_input_i,
  input  wire logic        sleep_i,
  output logic             match_flag_o
);

  // ==========================================================
  // registers and wires
  logic             count_direction;
  logic [2:0]       position_mode_select;
  logic             direction_source_select;
  logic             filter_output_enable;
  logic [2:0]       filter_clock_divider;
  logic [CNT_W-1:0] position_count_reg;
  logic [CNT_W-1:0] position_count_next;
  logic [CNT_W-1:0] max_count_reg;
  logic             flag_reg;
  logic             flag_set;
  logic             dir_reg;
  logic [2:0]       sync1_reg;
  logic [2:0]       sync2_reg;
  logic [2:0]       filt_out;
  logic [2:0]       sel_sig;
  logic [2:0]       prev_reg;
  logic [QPC_DIV_W-1:0] div_cnt_reg;
  logic [QPC_DIV_W-1:0] div_limit;
  logic             sample_tick;
  logic             bus_req;
  logic             bus_wr;
  logic             pos_wr;
  logic             run;
  logic             a_edge;
  logic             b_edge;
  logic             a_rise;
  logic             idx_rise;
  logic             enc_up;
  logic             tmr_up;
  logic             x2_mode;
  logic             x4_mode;
  logic             idx_mode;
  logic             max_mode;
  logic             enc_step;
  logic [15:0]      wdat;
  logic [15:0]      rdat;

  // ==========================================================
  // wishbone decode
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr  = bus_req && wb_we_i;
  assign pos_wr  = bus_wr && (wb_adr_i[7:2] == QPC_OFF_POS[7:2]);

  always_comb begin
    wdat = 16'h0000;
    if (wb_adr_i[7:2] == QPC_OFF_CTRL[7:2]) begin
      wdat = {4'h0, count_direction, position_mode_select, 7'h00,
              direction_source_select};
    end else if (wb_adr_i[7:2] == QPC_OFF_FILT[7:2]) begin
      wdat = {8'h00, filter_output_enable, filter_clock_divider, 4'h0};
    end else if (wb_adr_i[7:2] == QPC_OFF_POS[7:2]) begin
      wdat = position_count_reg;
    end else if (wb_adr_i[7:2] == QPC_OFF_MAX[7:2]) begin
      wdat = max_count_reg;
    end
    if (wb_sel_i[0]) begin
      wdat[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      wdat[15:8] = wb_dat_i[15:8];
    end
  end

  always_comb begin
    rdat = 16'h0000;
    if (wb_adr_i[7:2] == QPC_OFF_CTRL[7:2]) begin
      rdat = {4'h0, count_direction, position_mode_select, 7'h00,
              direction_source_select};
    end else if (wb_adr_i[7:2] == QPC_OFF_FILT[7:2]) begin
      rdat = {8'h00, filter_output_enable, filter_clock_divider, 4'h0};
    end else if (wb_adr_i[7:2] == QPC_OFF_POS[7:2]) begin
      rdat = position_count_reg;
    end else if (wb_adr_i[7:2] == QPC_OFF_MAX[7:2]) begin
      rdat = max_count_reg;
    end else if (wb_adr_i[7:2] == QPC_OFF_STAT[7:2]) begin
      rdat = {14'h0000, dir_reg, flag_reg};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= {16'h0000, rdat};
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_direction         <= QPC_RST_CTRL[QPC_CTRL_DIR_BIT];
      position_mode_select    <= QPC_RST_CTRL[QPC_CTRL_MODE_HI:QPC_CTRL_MODE_LO];
      direction_source_select <= QPC_RST_CTRL[QPC_CTRL_SRC_BIT];
    end else if (bus_wr && (wb_adr_i[7:2] == QPC_OFF_CTRL[7:2])) begin
      count_direction         <= wdat[QPC_CTRL_DIR_BIT];
      position_mode_select    <= wdat[QPC_CTRL_MODE_HI:QPC_CTRL_MODE_LO];
      direction_source_select <= wdat[QPC_CTRL_SRC_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filter_output_enable <= 1'b0;
      filter_clock_divider <= QPC_RST_DIV;
    end else if (bus_wr && (wb_adr_i[7:2] == QPC_OFF_FILT[7:2])) begin
      filter_output_enable <= wdat[QPC_FILT_OE_BIT];
      filter_clock_divider <= wdat[QPC_FILT_DIV_HI:QPC_FILT_DIV_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      max_count_reg <= QPC_RST_MAX;
    end else if (bus_wr && (wb_adr_i[7:2] == QPC_OFF_MAX[7:2])) begin
      max_count_reg <= wdat[CNT_W-1:0];
    end
  end

  // ==========================================================
  // input synchronisers and filters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {index_input_i, phase_b_input_i, phase_a_input_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign div_limit = (QPC_DIV_W'(1) << filter_clock_divider) - QPC_DIV_W'(1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_reg <= '0;
      sample_tick <= 1'b0;
    end else if (div_cnt_reg >= div_limit) begin
      div_cnt_reg <= '0;
      sample_tick <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + QPC_DIV_W'(1);
      sample_tick <= 1'b0;
    end
  end

  for (genvar ch = 0; ch < 3; ch++) begin : g_filt
    qpc_noise_filter u_filt (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .sample_en_i (sample_tick),
      .din_i       (sync2_reg[ch]),
      .dout_o      (filt_out[ch])
    );
  end

  assign sel_sig = filter_output_enable ? filt_out : sync2_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 3'h0;
    end else begin
      prev_reg <= sel_sig;
    end
  end

  // ==========================================================
  // edge and direction decode
  assign a_edge   = sel_sig[0] ^ prev_reg[0];
  assign b_edge   = sel_sig[1] ^ prev_reg[1];
  assign a_rise   = sel_sig[0] && !prev_reg[0];
  assign idx_rise = sel_sig[2] && !prev_reg[2];
  assign enc_up   = sel_sig[0] ^ prev_reg[1];
  assign tmr_up   = direction_source_select ? sel_sig[1] : count_direction;
  assign x2_mode  = (position_mode_select == QPC_MODE_X2_IDX) ||
                    (position_mode_select == QPC_MODE_X2_MAX);
  assign x4_mode  = (position_mode_select == QPC_MODE_X4_IDX) ||
                    (position_mode_select == QPC_MODE_X4_MAX);
  assign idx_mode = (position_mode_select == QPC_MODE_X2_IDX) ||
                    (position_mode_select == QPC_MODE_X4_IDX);
  assign max_mode = (position_mode_select == QPC_MODE_X2_MAX) ||
                    (position_mode_select == QPC_MODE_X4_MAX);
  assign enc_step = (x2_mode && a_edge) ||
                    (x4_mode && (a_edge ^ b_edge));
  assign run      = !sleep_i;

  // ==========================================================
  // position count next value
  always_comb begin
    position_count_next = position_count_reg;
    flag_set            = 1'b0;
    if (run && (x2_mode || x4_mode)) begin
      if (idx_mode && idx_rise) begin
        position_count_next = '0;
      end else if (enc_step && enc_up) begin
        if (max_mode && (position_count_reg == max_count_reg)) begin
          position_count_next = '0;
        end else begin
          position_count_next = position_count_reg + CNT_W'(1);
        end
      end else if (enc_step) begin
        if (max_mode && (position_count_reg == '0)) begin
          position_count_next = max_count_reg;
        end else begin
          position_count_next = position_count_reg - CNT_W'(1);
        end
      end
    end else if (run && (position_mode_select == QPC_MODE_TIMER) && a_rise) begin
      if (tmr_up) begin
        if (position_count_reg == max_count_reg) begin
          position_count_next = '0;
          flag_set            = 1'b1;
        end else begin
          position_count_next = position_count_reg + CNT_W'(1);
        end
      end else begin
        if (position_count_reg == '0) begin
          position_count_next = max_count_reg;
          flag_set            = 1'b1;
        end else begin
          position_count_next = position_count_reg - CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      position_count_reg <= QPC_RST_POS;
    end else if (pos_wr) begin
      position_count_reg <= wdat[CNT_W-1:0];
    end else begin
      position_count_reg <= position_count_next;
    end
  end

  // ==========================================================
  // status flag and direction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
    end else if (flag_set) begin
      flag_reg <= 1'b1;
    end else if (bus_wr && (wb_adr_i[7:2] == QPC_OFF_STAT[7:2]) && wb_sel_i[0] &&
                 wb_dat_i[QPC_STAT_FLAG_BIT]) begin
      flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_reg <= 1'b0;
    end else if (run && enc_step) begin
      dir_reg <= enc_up;
    end
  end

  assign match_flag_o = flag_reg;

  // ==========================================================
  // checks
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  wb_ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req_s |=> ack_pulse_s)
    else $error("bus ack not a single pulse after request");

  x2_up_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (position_mode_select == QPC_MODE_X2_MAX) && run && !pos_wr && a_edge && enc_up &&
      (position_count_reg != max_count_reg)
    |=> position_count_reg == $past(position_count_reg) + CNT_W'(1))
    else $error("x2 phase A edge did not increment");

  x2_b_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (position_mode_select == QPC_MODE_X2_MAX) && !pos_wr && !a_edge
    |=> $stable(position_count_reg))
    else $error("x2 count moved without phase A edge");

  x4_down_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (position_mode_select == QPC_MODE_X4_MAX) && run && !pos_wr && b_edge && !a_edge &&
      !enc_up && (position_count_reg != '0)
    |=> position_count_reg == $past(position_count_reg) - CNT_W'(1))
    else $error("x4 phase B edge did not decrement");

  index_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    idx_mode && run && !pos_wr && idx_rise |=> position_count_reg == '0)
    else $error("index pulse did not clear position");

  max_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    max_mode && run && !pos_wr && enc_step && enc_up &&
      (position_count_reg == max_count_reg)
    |=> position_count_reg == '0)
    else $error("max count match did not clear position");

  timer_match_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (position_mode_select == QPC_MODE_TIMER) && run && !pos_wr && a_rise && tmr_up &&
      (position_count_reg == max_count_reg)
    |=> (position_count_reg == '0) && match_flag_o)
    else $error("timer period match did not wrap and flag");

  timer_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (position_mode_select == QPC_MODE_TIMER) && run && !pos_wr && a_rise &&
      !direction_source_select && !count_direction && (position_count_reg != '0)
    |=> position_count_reg == $past(position_count_reg) - CNT_W'(1))
    else $error("timer ignored the direction bit");

  sleep_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_i && !pos_wr |=> $stable(position_count_reg))
    else $error("count moved during sleep");

  filter_off_a: assert property (@(posedge clk_i)
    rst_i |=> !filter_output_enable)
    else $error("filter enabled after reset");

endmodule : qpc_counter

// ### rtl/qpc_pkg.sv
// Purpose: shared constants for the quadrature position counter
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   registers hold 16 bits in the low lanes, upper bits read zero
package qpc_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] QPC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] QPC_OFF_FILT   = 8'h04;
  localparam logic [7:0] QPC_OFF_POS    = 8'h08;
  localparam logic [7:0] QPC_OFF_MAX    = 8'h0c;
  localparam logic [7:0] QPC_OFF_STAT   = 8'h10;

  // ==========================================================
  // field positions
  localparam int unsigned QPC_CTRL_DIR_BIT   = 11;
  localparam int unsigned QPC_CTRL_MODE_HI   = 10;
  localparam int unsigned QPC_CTRL_MODE_LO   = 8;
  localparam int unsigned QPC_CTRL_SRC_BIT   = 0;
  localparam int unsigned QPC_FILT_OE_BIT    = 7;
  localparam int unsigned QPC_FILT_DIV_HI    = 6;
  localparam int unsigned QPC_FILT_DIV_LO    = 4;
  localparam int unsigned QPC_STAT_FLAG_BIT  = 0;
  localparam int unsigned QPC_STAT_DIR_BIT   = 1;

  // ==========================================================
  // reset values
  localparam logic [15:0] QPC_RST_CTRL = 16'h0000;
  localparam logic [15:0] QPC_RST_POS  = 16'h0000;
  localparam logic [15:0] QPC_RST_MAX  = 16'hffff;
  localparam logic [2:0]  QPC_RST_DIV  = 3'h0;

  // ==========================================================
  // position mode codes
  localparam logic [2:0] QPC_MODE_OFF    = 3'h0;
  localparam logic [2:0] QPC_MODE_TIMER  = 3'h1;
  localparam logic [2:0] QPC_MODE_X2_IDX = 3'h4;
  localparam logic [2:0] QPC_MODE_X2_MAX = 3'h5;
  localparam logic [2:0] QPC_MODE_X4_IDX = 3'h6;
  localparam logic [2:0] QPC_MODE_X4_MAX = 3'h7;

  // ==========================================================
  // filter timing
  localparam int unsigned QPC_FILT_SAMPLES = 3;
  localparam int unsigned QPC_DIV_W        = 8;

endpackage : qpc_pkg

// ### rtl/qpc_noise_filter.sv
// Purpose: three-sample digital noise filter for one input channel
// Assumes: din_i is already synchronised to clk_i
// Notes:   output moves only after three equal samples taken on sample_en_i
`timescale 1ns/1ps
module qpc_noise_filter
  import qpc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sample_en_i,
  input  wire logic din_i,
  output logic      dout_o
);

  // ==========================================================
  // sample history
  logic [1:0] hist_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hist_reg <= 2'h0;
    end else if (sample_en_i) begin
      hist_reg <= {hist_reg[0], din_i};
    end
  end

  // ==========================================================
  // output update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_o <= 1'b0;
    end else if (sample_en_i && (hist_reg == {2{din_i}})) begin
      dout_o <= din_i;
    end
  end

  // ==========================================================
  // checks
  stable_three_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(dout_o) |-> $past(sample_en_i) && ($past(hist_reg) == {2{dout_o}})
      && ($past(din_i) == dout_o))
    else $error("filter output moved without three stable samples");

endmodule : qpc_noise_filter

// ### testbench/qpc_encoder_model.sv
// Purpose: behavioural quadrature encoder on a motor shaft
// Assumes: pins change by non-blocking assignment just after a rising clock edge
// Notes:   shaft states run 00,10,11,01 (phase a, phase b) when turning up
`timescale 1ns/1ps
module qpc_encoder_model #(
  parameter int HOLD = 40
)(
  input  wire logic clk_i,
  output logic      phase_a_o,
  output logic      phase_b_o,
  output logic      index_o
);
  // ==========================================================
  // shaft state
  logic [1:0] pos_q;

  initial begin
    pos_q     = 2'h0;
    phase_a_o = 1'b0;
    phase_b_o = 1'b0;
    index_o   = 1'b0;
  end

  // ==========================================================
  // motion tasks
  task automatic hold_for(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold_for

  task automatic step(input logic up);
    pos_q = up ? pos_q + 2'h1 : pos_q - 2'h1;
    @(posedge clk_i);
    phase_a_o <= pos_q[1] ^ pos_q[0];
    phase_b_o <= pos_q[1];
    hold_for(HOLD);
  endtask : step

  task automatic glitch_a(input int n);
    @(posedge clk_i);
    phase_a_o <= ~phase_a_o;
    hold_for(n);
    phase_a_o <= ~phase_a_o;
    hold_for(HOLD);
  endtask : glitch_a

  task automatic pulse_a();
    glitch_a(HOLD);
  endtask : pulse_a

  task automatic index_pulse();
    @(posedge clk_i);
    index_o <= 1'b1;
    hold_for(HOLD);
    index_o <= 1'b0;
    hold_for(HOLD);
  endtask : index_pulse
endmodule : qpc_encoder_model

// ### testbench/tb.sv
// Purpose: self-checking bench for the quadrature position counter
// Assumes: encoder model holds each shaft state for 40 clocks
// Notes:   registers reached through classic wishbone cycles
`timescale 1ns/1ps
module tb
  import qpc_pkg::*;
;
  // ==========================================================
  // signals
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        phase_a;
  logic        phase_b;
  logic        index_p;
  logic        sleep_i;
  logic        match_flag_o;
  logic [15:0] rv;
  int          error_cnt = 0;
  int          checked   = 0;
  logic [2:0]  mode_c [4] = '{3'h4, 3'h5, 3'h6, 3'h7};
  logic [15:0] exp_up [4] = '{16'h0004, 16'h0000, 16'h0008, 16'h0000};
  logic [15:0] exp_dn [4] = '{16'h0003, 16'h0003, 16'h0005, 16'h0001};
  logic [15:0] exp_ix [4] = '{16'h0000, 16'h0003, 16'h0000, 16'h0001};

  always #20 clk_i = ~clk_i;

  qpc_counter #(.CNT_W(16)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_a_input_i(phase_a),
    .phase_b_input_i(phase_b), .index_input_i(index_p), .sleep_i(sleep_i),
    .match_flag_o(match_flag_o));

  qpc_encoder_model #(.HOLD(40)) enc_u (
    .clk_i(clk_i), .phase_a_o(phase_a), .phase_b_o(phase_b), .index_o(index_p));

  // ==========================================================
  // checking and bus tasks
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [15:0] wd,
                          input logic [3:0] sel, output logic [15:0] rd);
    int n;
    n = 0;
    rd = 16'h0000;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {16'h0000, wd};
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      chk("bus ack", 16'h0001, 16'h0000);
      report_and_stop();
    end else begin
      rd = wb_dat_o[15:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
    end
  endtask : wb_cycle

  task automatic wb_write(input logic [7:0] adr, input logic [15:0] d);
    logic [15:0] unused;
    wb_cycle(1'b1, adr, d, 4'hf, unused);
  endtask : wb_write

  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [15:0] exp);
    wb_cycle(1'b0, adr, 16'h0000, 4'hf, rv);
    chk(name, exp, rv);
  endtask : rd_chk

  task automatic test_end(input string name);
    $display("test %s done, mismatches so far %0d", name, error_cnt);
  endtask : test_end

  // ==========================================================
  // test sequence
  initial begin
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    wb_adr_i <= 8'h00;
    wb_sel_i <= 4'hf;
    wb_dat_i <= 32'h0000_0000;
    sleep_i  <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl", QPC_OFF_CTRL, QPC_RST_CTRL);
    rd_chk("filt", QPC_OFF_FILT, 16'h0000);
    rd_chk("pos", QPC_OFF_POS, QPC_RST_POS);
    rd_chk("max", QPC_OFF_MAX, QPC_RST_MAX);
    rd_chk("unmapped", 8'h14, 16'h0000);
    wb_cycle(1'b1, QPC_OFF_MAX, 16'h1234, 4'h1, rv);
    rd_chk("max low lane", QPC_OFF_MAX, 16'hff34);
    wb_cycle(1'b1, QPC_OFF_MAX, 16'h5600, 4'h2, rv);
    rd_chk("max high lane", QPC_OFF_MAX, 16'h5634);
    test_end("reset");
    wb_write(QPC_OFF_MAX, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      wb_write(QPC_OFF_POS, 16'h0000);
      wb_write(QPC_OFF_CTRL, {5'h00, mode_c[i], 8'h00});
      repeat (8) enc_u.step(1'b1);
      rd_chk("pos up", QPC_OFF_POS, exp_up[i]);
      repeat (3) enc_u.step(1'b0);
      rd_chk("pos down", QPC_OFF_POS, exp_dn[i]);
      wb_cycle(1'b0, QPC_OFF_STAT, 16'h0000, 4'hf, rv);
      chk("dir down", 16'h0000, {15'h0000, rv[1]});
      enc_u.index_pulse();
      rd_chk("pos index", QPC_OFF_POS, exp_ix[i]);
      wb_write(QPC_OFF_CTRL, 16'h0200);
      repeat (3) enc_u.step(1'b1);
      rd_chk("pos hold", QPC_OFF_POS, exp_ix[i]);
    end
    test_end("encoder modes");
    wb_write(QPC_OFF_MAX, 16'h0002);
    wb_write(QPC_OFF_POS, 16'h0000);
    wb_write(QPC_OFF_CTRL, 16'h0900);
    repeat (2) enc_u.pulse_a();
    rd_chk("timer up", QPC_OFF_POS, 16'h0002);
    enc_u.pulse_a();
    rd_chk("timer wrap", QPC_OFF_POS, 16'h0000);
    chk("match flag", 16'h0001, {15'h0000, match_flag_o});
    wb_write(QPC_OFF_STAT, 16'h0001);
    wb_cycle(1'b0, QPC_OFF_STAT, 16'h0000, 4'hf, rv);
    chk("flag clear", 16'h0000, {15'h0000, rv[0]});
    wb_write(QPC_OFF_CTRL, 16'h0100);
    enc_u.pulse_a();
    rd_chk("timer down", QPC_OFF_POS, 16'h0002);
    wb_write(QPC_OFF_CTRL, 16'h0901);
    enc_u.pulse_a();
    rd_chk("src b low", QPC_OFF_POS, 16'h0001);
    repeat (2) enc_u.step(1'b1);
    enc_u.pulse_a();
    rd_chk("src b high", QPC_OFF_POS, 16'h0001);
    wb_write(QPC_OFF_CTRL, 16'h0600);
    rd_chk("pos kept x4", QPC_OFF_POS, 16'h0001);
    wb_write(QPC_OFF_CTRL, 16'h0901);
    rd_chk("pos kept timer", QPC_OFF_POS, 16'h0001);
    test_end("timer");
    wb_write(QPC_OFF_CTRL, 16'h0600);
    sleep_i <= 1'b1;
    repeat (2) enc_u.step(1'b1);
    sleep_i <= 1'b0;
    rd_chk("sleep hold", QPC_OFF_POS, 16'h0001);
    enc_u.step(1'b1);
    rd_chk("after sleep", QPC_OFF_POS, 16'h0002);
    wb_cycle(1'b0, QPC_OFF_STAT, 16'h0000, 4'hf, rv);
    chk("dir up", 16'h0001, {15'h0000, rv[1]});
    test_end("sleep");
    wb_write(QPC_OFF_CTRL, 16'h0000);
    wb_write(QPC_OFF_FILT, 16'h00a0);
    enc_u.hold_for(30);
    wb_write(QPC_OFF_POS, 16'h0000);
    wb_write(QPC_OFF_CTRL, 16'h0600);
    enc_u.glitch_a(6);
    rd_chk("glitch filtered", QPC_OFF_POS, 16'h0000);
    enc_u.step(1'b1);
    rd_chk("filtered step", QPC_OFF_POS, 16'h0001);
    wb_write(QPC_OFF_FILT, 16'h00f0);
    enc_u.step(1'b1);
    rd_chk("slow filter", QPC_OFF_POS, 16'h0001);
    enc_u.hold_for(450);
    rd_chk("slow filter late", QPC_OFF_POS, 16'h0002);
    wb_write(QPC_OFF_CTRL, 16'h0000);
    wb_write(QPC_OFF_FILT, 16'h0000);
    wb_write(QPC_OFF_CTRL, 16'h0900);
    enc_u.glitch_a(6);
    rd_chk("unfiltered pulse", QPC_OFF_POS, 16'h0000);
    test_end("filter");
    report_and_stop();
  end
endmodule : tb
